// File: bench/phy_led_reset_strap_logic_tb.sv
// self-checking bench for the led, reset and strap block
// assumes plrs_board as far side and the bound checker
`timescale 1ns/1ps
`include "plrs_consts.svh"
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module phy_led_reset_strap_logic_tb;
	logic sys_clk = 0, reset_n = 0, regWrite = 0, regRead = 0, irqEvent = 0, colFunc = 0;
	logic strapFit = 0, hostPdLow = 0, powerdownOrIrqIn, dsel;
	logic [7:0] regAddr = 8'h00;
	logic [15:0] regWrData = 16'h0000, regRdData, rd;
	logic [1:0] ledMode = 2'h1;
	logic [3:0] rxdFunc = 4'h0;
	logic [4:0] strapVal = 5'h00, phyAddrStrapIn, phyAddrStrapOut, phyAddrStrapOe, phyAddr, v;
	plrs_pkg::plrs_link_status_t linkStatus = '0;
	logic linkIndicator, speedIndicator, activityCollisionIndicator, ledOe;
	logic powerdownOrIrqOut, powerdownOrIrqOe, powerDown, isolate;
	logic [31:0] seed = 32'h3df9_33c3, r;
	int num_errors = 0, total_checks = 0, lit, dark;
	always #12.5 sys_clk = ~sys_clk;
	plrs_top #(.BLINK_HALF_CYCLES(4)) dut (.*);
	plrs_board board (.strapVal(strapVal), .strapFit(strapFit), .padOut(phyAddrStrapOut),
		.padOe(phyAddrStrapOe), .hostPdLow(hostPdLow), .irqOe(powerdownOrIrqOe),
		.strapPin(phyAddrStrapIn), .pdPin(powerdownOrIrqIn));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic expAct(logic [1:0] m, plrs_pkg::plrs_link_status_t s, logic d);
		if (m == `PLRS_LED_MODE2) return s.collision;
		if (m == `PLRS_LED_MODE3) return d ? s.fullDuplex : s.collision;
		return s.txActive | s.rxActive;
	endfunction
	task automatic tick(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [15:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rdr(logic [7:0] a);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 rd = regRdData;
	endtask
	task automatic rst(logic [4:0] sv, logic f, int n);
		@(posedge sys_clk);
		strapVal <= sv;
		strapFit <= f;
		reset_n <= 1'b0;
		repeat (n) @(posedge sys_clk);
		reset_n <= 1'b1;
		tick(3);
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// about twenty-seven times the expected run
	initial begin
		#(25 * 40000);
		num_errors++;
		give_verdict();
	end
	initial begin
		rst(5'h00, 1'b0, 5);
		`CHK(phyAddr, 5'h01)
		`CHK(isolate, 1'b0)
		`CHK(ledOe, 1'b1)
		`CHK(phyAddrStrapOe, 5'h1f)
		$display("test defaults done");
		for (int i = 0; i < 4; i++) begin
			v = i == 0 ? 5'h00 : i == 1 ? 5'h1f : 5'(rnd());
			wr(8'h00, 16'h0007);
			rst(v, 1'b1, 40);
			`CHK(phyAddr, v)
			`CHK(isolate, v == 5'h00)
			rdr(8'h00);
			`CHK(rd, 16'h0000)
			wr(8'h08, 16'h0000);
			rdr(8'h08);
			`CHK(rd[4:0], 5'h00)
			`CHK(isolate, v == 5'h00)
			rdr(8'hfc);
			`CHK(rd, 16'h0000)
		end
		$display("test straps done");
		for (int i = 0; i < 200; i++) begin
			r = rnd();
			dsel = r[8];
			wr(8'h00, {14'h0000, dsel, 1'b0});
			linkStatus <= r[5:0];
			ledMode <= r[7:6];
			colFunc <= r[9];
			rxdFunc <= r[13:10];
			tick(4);
			`CHK(speedIndicator, r[4])
			`CHK(activityCollisionIndicator, expAct(ledMode, linkStatus, dsel))
			`CHK(phyAddrStrapOut, r[13:9])
			if (!ledMode[1] || !(r[2] | r[1]) || !r[5]) `CHK(linkIndicator, r[5])
		end
		$display("test leds done");
		@(posedge sys_clk);
		ledMode <= 2'h2;
		linkStatus <= 6'h24;
		lit = 0;
		dark = 0;
		repeat (24) begin
			tick(1);
			if (linkIndicator === 1'b1) lit++;
			else dark++;
		end
		`CHK(lit > 4 && dark > 4, 1'b1)
		$display("test blink done");
		wr(8'h00, 16'h0000);
		hostPdLow <= 1'b1;
		tick(3);
		`CHK(powerDown, 1'b1)
		hostPdLow <= 1'b0;
		tick(3);
		`CHK(powerDown, 1'b0)
		wr(8'h00, 16'h0005);
		@(posedge sys_clk);
		irqEvent <= 1'b1;
		@(posedge sys_clk);
		irqEvent <= 1'b0;
		tick(3);
		`CHK(powerdownOrIrqIn, 1'b0)
		rdr(8'h04);
		`CHK(rd[0], 1'b1)
		wr(8'h04, 16'h0001);
		tick(3);
		`CHK(powerdownOrIrqIn, 1'b1)
		$display("test pin done");
		give_verdict();
	end
endmodule
`default_nettype wire

// File: bench/plrs_board.sv
// board side: strap resistors, pin pulls, host power-down drive
// assumes the bench feeds the design's pin enables
`timescale 1ns/1ps
`default_nettype none
module plrs_board (
	input wire logic [4:0] strapVal,
	input wire logic strapFit,
	input wire logic [4:0] padOut,
	input wire logic [4:0] padOe,
	input wire logic hostPdLow,
	input wire logic irqOe,
	output logic [4:0] strapPin,
	output logic pdPin
);
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			strapPin[i] = padOe[i] ? padOut[i] : (strapFit ? strapVal[i] : (i == 0));
		end
	end
	assign pdPin = !(hostPdLow || irqOe);
endmodule
`default_nettype wire

// File: bench/plrs_top_asserts.sv
// pin checks on the top module
// assumes a blink half period well under 8 cycles
`timescale 1ns/1ps
`include "plrs_consts.svh"
`default_nettype none
module plrs_top_asserts #(
	parameter int unsigned BLINK_HALF_CYCLES = 4
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [1:0] ledMode,
	input wire plrs_pkg::plrs_link_status_t linkStatus,
	input wire logic linkIndicator,
	input wire logic speedIndicator,
	input wire logic activityCollisionIndicator,
	input wire logic ledOe,
	input wire logic [`PLRS_ADDR_MSB:0] phyAddrStrapOut,
	input wire logic [`PLRS_ADDR_MSB:0] phyAddrStrapOe,
	input wire logic colFunc,
	input wire logic [3:0] rxdFunc,
	input wire logic powerdownOrIrqIn,
	input wire logic powerdownOrIrqOut,
	input wire logic powerDown,
	input wire logic isolate
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	wire logic act = linkStatus.txActive || linkStatus.rxActive;
	sequence litActive;
		(ledOe && ledMode == `PLRS_LED_MODE2 && linkStatus.link && act && linkIndicator)[*8];
	endsequence
	sequence idleLink;
		(ledOe && ledMode[1] && linkStatus.link && !act)[*2];
	endsequence
	speed_follows_a: assert property (ledOe |=> speedIndicator == $past(linkStatus.speed100))
		else $error("speed led wrong");
	link_mode1_a: assert property (ledOe && !ledMode[1] |=> linkIndicator == $past(linkStatus.link))
		else $error("link led wrong");
	act_mode1_a: assert property (ledOe && !ledMode[1] |=> activityCollisionIndicator == $past(act))
		else $error("activity led wrong");
	col_mode2_a: assert property (ledOe && ledMode == `PLRS_LED_MODE2 |=>
		activityCollisionIndicator == $past(linkStatus.collision)) else $error("collision led wrong");
	link_idle_a: assert property (idleLink |=> linkIndicator) else $error("idle link led off");
	// too long lit means the blink never started
	link_blink_a: assert property (not litActive) else $error("no blink");
	pd_cause_a: assert property (powerDown |-> $past(!powerdownOrIrqIn)) else $error("bad power-down");
	od_never_high_a: assert property (!powerdownOrIrqOut) else $error("pin driven high");
	isolate_fixed_a: assert property (ledOe |-> $stable(isolate)) else $error("isolate moved");
	strap_role_a: assert property (phyAddrStrapOe[0] |=>
		phyAddrStrapOut == $past({rxdFunc, colFunc})) else $error("strap pin role wrong");
endmodule
bind plrs_top plrs_top_asserts #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) chk (.*);
`default_nettype wire

// File: verilog/plrs_consts.svh
// constants for the led, reset and strap block: offsets, fields, resets, timing
// assumes inclusion by bare name from the bench, the checker and the top module
`ifndef PLRS_CONSTS_SVH
`define PLRS_CONSTS_SVH

`define PLRS_ADDR_W 8
`define PLRS_DATA_W 16

`define PLRS_OFF_CTRL 8'h00
`define PLRS_OFF_STATUS 8'h04
`define PLRS_OFF_PHY_CONTROL 8'h08

`define PLRS_CTRL_IRQ_PIN_SEL 0
`define PLRS_CTRL_DUPLEX_SEL 1
`define PLRS_CTRL_IRQ_EN 2

`define PLRS_STAT_IRQ_PEND 0
`define PLRS_STAT_POWER_DOWN 1
`define PLRS_STAT_ISOLATE 2
`define PLRS_STAT_LINK 3
`define PLRS_STAT_SPEED100 4
`define PLRS_STAT_ADDR_LSB 8
`define PLRS_STAT_ADDR_MSB 12

`define PLRS_ADDR_MSB 4
`define PLRS_PHY_ADDR_RESET 5'h01
`define PLRS_PHY_ADDR_ISOLATE 5'h00
`define PLRS_DATA_ZERO 16'h0000

`define PLRS_LED_MODE1 2'h1
`define PLRS_LED_MODE2 2'h2
`define PLRS_LED_MODE3 2'h3

`define PLRS_CLK_PERIOD_NS 25
`define PLRS_RESET_MIN_NS 1000
`define PLRS_BLINK_HALF_NS 50000000
`define PLRS_BLINK_CNT_W 22

`endif

// File: verilog/plrs_pkg.sv
// types shared by the led, reset and strap block
// assumes plrs_consts.svh sits on the include path
`default_nettype none

package plrs_pkg;

	typedef struct packed {
		logic link;
		logic speed100;
		logic fullDuplex;
		logic txActive;
		logic rxActive;
		logic collision;
	} plrs_link_status_t;

	typedef struct packed {
		logic irqEnable;
		logic duplexSel;
		logic irqPinSel;
	} plrs_ctrl_t;

	typedef enum logic [1:0] {
		PLRS_ST_SAMPLE = 2'b01,
		PLRS_ST_RUN = 2'b10
	} plrs_state_t;

endpackage

`default_nettype wire

// File: verilog/plrs_top.sv
// status leds, reset, power-down/interrupt pin and phy address straps
// assumes one 40 MHz clock, synchronous pins and a simple strobe register port
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "plrs_consts.svh"
`default_nettype none

module plrs_top #(
	parameter int unsigned BLINK_HALF_CYCLES = `PLRS_BLINK_HALF_NS / `PLRS_CLK_PERIOD_NS
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [`PLRS_ADDR_W-1:0] regAddr,
	input wire logic [`PLRS_DATA_W-1:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [`PLRS_DATA_W-1:0] regRdData,
	input wire logic [1:0] ledMode,
	input wire plrs_pkg::plrs_link_status_t linkStatus,
	input wire logic irqEvent,
	output logic linkIndicator,
	output logic speedIndicator,
	output logic activityCollisionIndicator,
	output logic ledOe,
	input wire logic [`PLRS_ADDR_MSB:0] phyAddrStrapIn,
	output logic [`PLRS_ADDR_MSB:0] phyAddrStrapOut,
	output logic [`PLRS_ADDR_MSB:0] phyAddrStrapOe,
	input wire logic colFunc,
	input wire logic [3:0] rxdFunc,
	input wire logic powerdownOrIrqIn,
	output logic powerdownOrIrqOut,
	output logic powerdownOrIrqOe,
	output logic powerDown,
	output logic isolate,
	output logic [`PLRS_ADDR_MSB:0] phyAddr
);

	plrs_pkg::plrs_state_t state;
	plrs_pkg::plrs_ctrl_t ctrl;
	logic irqPending;
	logic [`PLRS_BLINK_CNT_W-1:0] blinkCnt;
	logic blinkTick;
	logic blinkPhase;
	logic activity;
	logic running;
	logic writeCtrl;
	logic writeStatus;
	logic writePhyCtrl;
	logic [`PLRS_DATA_W-1:0] next_rdData;
	logic next_link;
	logic next_actCol;
	logic blinkWrap;
	logic irqSet;
	logic irqClear;
	logic [`PLRS_DATA_W-1:0] ctrlWord;
	logic [`PLRS_DATA_W-1:0] statusWord;
	logic [`PLRS_DATA_W-1:0] phyCtrlWord;

	function automatic logic regHit(
		input logic [`PLRS_ADDR_W-1:0] addr,
		input logic [`PLRS_ADDR_W-1:0] offset
	);
		regHit = (addr == offset);
	endfunction

	// lit while linked, dark in the odd half of the blink period
	function automatic logic blinkedLink(
		input logic link,
		input logic phase
	);
		blinkedLink = link & ~phase;
	endfunction

	assign running = (state == plrs_pkg::PLRS_ST_RUN);
	assign activity = linkStatus.txActive | linkStatus.rxActive;
	assign writeCtrl = regWrite & regHit(regAddr, `PLRS_OFF_CTRL);
	assign writeStatus = regWrite & regHit(regAddr, `PLRS_OFF_STATUS);
	assign writePhyCtrl = regWrite & regHit(regAddr, `PLRS_OFF_PHY_CONTROL);
	assign blinkWrap = (blinkCnt == `PLRS_BLINK_CNT_W'(BLINK_HALF_CYCLES - 1));
	assign irqSet = irqEvent & running;
	assign irqClear = writeStatus & regWrData[`PLRS_STAT_IRQ_PEND];

	// async reset entry
	// the reset pin is used directly; any low level re-inits, so a 1 us hold always does
	// sample then run
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= plrs_pkg::PLRS_ST_SAMPLE;
		end else begin
			case (state)
				plrs_pkg::PLRS_ST_SAMPLE: begin
					state <= plrs_pkg::PLRS_ST_RUN;
				end
				plrs_pkg::PLRS_ST_RUN: begin
					state <= plrs_pkg::PLRS_ST_RUN;
				end
				default: begin
					state <= plrs_pkg::PLRS_ST_SAMPLE;
				end
			endcase
		end
	end

	// unstrapped default one
	// straps caught on the first edge after release, never under the async reset
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			phyAddr <= `PLRS_PHY_ADDR_RESET;
		end else if (!running) begin
			phyAddr <= phyAddrStrapIn;
		end else if (writePhyCtrl) begin
			phyAddr <= regWrData[`PLRS_ADDR_MSB:0];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			isolate <= 1'b0;
		end else if (!running) begin
			isolate <= (phyAddrStrapIn == `PLRS_PHY_ADDR_ISOLATE);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= '0;
		end else if (writeCtrl) begin
			ctrl.irqPinSel <= regWrData[`PLRS_CTRL_IRQ_PIN_SEL];
			ctrl.duplexSel <= regWrData[`PLRS_CTRL_DUPLEX_SEL];
			ctrl.irqEnable <= regWrData[`PLRS_CTRL_IRQ_EN];
		end
	end

	// sticky interrupt; a new event beats a same-cycle write-one clear
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irqPending <= 1'b0;
		end else if (irqSet) begin
			irqPending <= 1'b1;
		end else if (irqClear) begin
			irqPending <= 1'b0;
		end
	end

	// power-down function default
	// pin only counts as power-down while the irq function is off
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			powerDown <= 1'b0;
		end else begin
			powerDown <= running & ~ctrl.irqPinSel & ~powerdownOrIrqIn;
		end
	end

	// open-drain interrupt drive
	// output data stays low; only the enable moves, so the pin is never driven high
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			powerdownOrIrqOut <= 1'b0;
		end else begin
			powerdownOrIrqOut <= 1'b0;
		end
	end

	// enable needs the pin handed over, the source allowed and an event pending
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			powerdownOrIrqOe <= 1'b0;
		end else begin
			powerdownOrIrqOe <= ctrl.irqPinSel & ctrl.irqEnable & irqPending;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			blinkCnt <= '0;
		end else if (blinkWrap) begin
			blinkCnt <= '0;
		end else begin
			blinkCnt <= blinkCnt + 1'b1;
		end
	end

	// one-cycle enable per half period; the only slower rate in the block
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			blinkTick <= 1'b0;
		end else begin
			blinkTick <= blinkWrap;
		end
	end

	// phase restarts on idle so a burst always opens with the led lit
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			blinkPhase <= 1'b0;
		end else if (!activity) begin
			blinkPhase <= 1'b0;
		end else if (blinkTick) begin
			blinkPhase <= ~blinkPhase;
		end
	end

	// mode input decode
	// an unused mode value falls back to mode 1 behaviour
	always_comb begin
		next_link = linkStatus.link;
		case (ledMode)
			`PLRS_LED_MODE2: begin
				next_link = blinkedLink(linkStatus.link, blinkPhase);
			end
			`PLRS_LED_MODE3: begin
				next_link = blinkedLink(linkStatus.link, blinkPhase);
			end
			default: begin
				next_link = linkStatus.link;
			end
		endcase
	end

	// act/col source per mode; mode 0 shows activity like mode 1
	always_comb begin
		next_actCol = activity;
		case (ledMode)
			`PLRS_LED_MODE2: begin
				next_actCol = linkStatus.collision;
			end
			`PLRS_LED_MODE3: begin
				next_actCol = ctrl.duplexSel ? linkStatus.fullDuplex : linkStatus.collision;
			end
			default: begin
				next_actCol = activity;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			linkIndicator <= 1'b0;
		end else begin
			linkIndicator <= running & next_link;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			speedIndicator <= 1'b0;
		end else begin
			speedIndicator <= running & linkStatus.speed100;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			activityCollisionIndicator <= 1'b0;
		end else begin
			activityCollisionIndicator <= running & next_actCol;
		end
	end

	// led pins stay released until the straps have been read
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ledOe <= 1'b0;
		end else begin
			ledOe <= running;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			phyAddrStrapOut <= '0;
		end else begin
			phyAddrStrapOut <= {rxdFunc, colFunc};
		end
	end

	// pins stay released while straps are read, so board resistors set the level
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			phyAddrStrapOe <= '0;
		end else begin
			phyAddrStrapOe <= {(`PLRS_ADDR_MSB+1){running}};
		end
	end

	// register words built apart so the select below stays a plain chain
	always_comb begin
		ctrlWord = `PLRS_DATA_ZERO;
		ctrlWord[`PLRS_CTRL_IRQ_PIN_SEL] = ctrl.irqPinSel;
		ctrlWord[`PLRS_CTRL_DUPLEX_SEL] = ctrl.duplexSel;
		ctrlWord[`PLRS_CTRL_IRQ_EN] = ctrl.irqEnable;
	end

	always_comb begin
		statusWord = `PLRS_DATA_ZERO;
		statusWord[`PLRS_STAT_IRQ_PEND] = irqPending;
		statusWord[`PLRS_STAT_POWER_DOWN] = powerDown;
		statusWord[`PLRS_STAT_ISOLATE] = isolate;
		statusWord[`PLRS_STAT_LINK] = linkStatus.link;
		statusWord[`PLRS_STAT_SPEED100] = linkStatus.speed100;
	end

	always_comb begin
		phyCtrlWord = `PLRS_DATA_ZERO;
		phyCtrlWord[`PLRS_ADDR_MSB:0] = phyAddr;
		phyCtrlWord[`PLRS_STAT_ADDR_MSB:`PLRS_STAT_ADDR_LSB] = phyAddrStrapIn;
	end

	// read mux, unmapped offsets read zero
	always_comb begin
		next_rdData = `PLRS_DATA_ZERO;
		if (regHit(regAddr, `PLRS_OFF_CTRL)) begin
			next_rdData = ctrlWord;
		end else if (regHit(regAddr, `PLRS_OFF_STATUS)) begin
			next_rdData = statusWord;
		end else if (regHit(regAddr, `PLRS_OFF_PHY_CONTROL)) begin
			next_rdData = phyCtrlWord;
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			regRdData <= `PLRS_DATA_ZERO;
		end else if (regRead) begin
			regRdData <= next_rdData;
		end else begin
			regRdData <= `PLRS_DATA_ZERO;
		end
	end

endmodule

`default_nettype wire
